// File: rtl/tcg_guard.v
`timescale 1ns/10ps
`include "tcg_consts.vh"

module tcg_guard #(
   parameter TICK_CYCLES = `TCG_TICK_CYCLES,
   parameter TW          = 8
) (
   // Clock and reset
   input  wire        clk_in,
   input  wire        reset_n_in,
   // Avalon-MM slave
   input  wire [3:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   input  wire [3:0]  avs_byteenable_in,
   output reg  [31:0] avs_readdata_out,
   output wire        avs_waitrequest_out,
   // Measurement path
   input  wire [15:0] temp_in,
   input  wire        sensor_fault_in,
   // Outputs
   output reg         compressor_out,
   output reg         lamp_out,
   output reg         low_alarm_enable_out
);

   localparam ST_NORMAL   = 2'b00;
   localparam ST_PULLDOWN = 2'b01;
   localparam ST_FAULT    = 2'b10;

   // Registers
   reg [15:0] setpoint;
   reg [15:0] hyst;
   reg [15:0] floor_lim;
   reg [15:0] ceil_lim;
   reg        heat_cool_select;
   reg [15:0] low_temp_threshold;
   // Stored time settings start at their defaults and survive reset
   reg [31:0] times_a_sw = `TCG_RST_TIMES_A;
   reg [31:0] times_b_sw = `TCG_RST_TIMES_B;
   reg [31:0] times_a;
   reg [31:0] times_b;
   reg        pulldown_req;
   reg        refused;
   reg        rd_done;
   // Synchronisers
   reg        fault_s1;
   reg        fault_s2;
   reg [15:0] temp_s1;
   reg [15:0] temp_s2;
   // Control
   reg [24:0] tick_div;
   reg        tick;
   reg        first_tick;
   reg [1:0]  state;
   reg        fault_off;
   reg        started_once;
   reg [15:0] hours_run;
   reg [15:0] hold_min;
   reg [7:0]  blink;
   reg [8:0]  min_ticks;
   // Control decision
   reg        next_on;
   reg        phase_restart;
   reg [1:0]  next_state;
   reg        next_fault_off;
   reg        want_on;
   reg        can_start;
   reg        can_stop;

   wire [TW-1:0] since_power;
   wire [TW-1:0] since_start;
   wire [TW-1:0] since_change;
   wire [TW-1:0] phase_min;
   wire          bus_wr;
   wire          bus_rd;
   wire          fault;
   wire [15:0]   wdata16;
   wire          u_phase_min_edge;

   // ****************************************
   // Helper functions
   // ****************************************
   // Signed compare a > b
   function sgt;
      input [15:0] a;
      input [15:0] b;
      begin
         sgt = ($signed(a) > $signed(b));
      end
   endfunction

   // Elapsed minutes meet a limit, zero limit always met
   function met;
      input [TW-1:0] elapsed;
      input [7:0]    limit;
      begin
         met = (limit == 8'h00) || (elapsed >= limit[TW-1:0]);
      end
   endfunction

   // ****************************************
   // Avalon-MM slave
   // ****************************************
   // Single-cycle wait lets read data land in a flop
   assign avs_waitrequest_out = (avs_read_in && !rd_done);
   assign bus_wr  = avs_write_in;
   assign bus_rd  = avs_read_in && !rd_done;
   assign wdata16 = avs_writedata_in[15:0];

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_done          <= 1'b0;
         avs_readdata_out <= 32'h00000000;
      end else begin
         rd_done <= bus_rd;
         if (bus_rd) begin
            case (avs_address_in)
               `TCG_REG_SETPOINT: avs_readdata_out <= {16'h0000, setpoint};
               `TCG_REG_HYST:     avs_readdata_out <= {16'h0000, hyst};
               `TCG_REG_FLOOR:    avs_readdata_out <= {16'h0000, floor_lim};
               `TCG_REG_CEIL:     avs_readdata_out <= {16'h0000, ceil_lim};
               `TCG_REG_MODE:     avs_readdata_out <= {31'h00000000, heat_cool_select};
               `TCG_REG_TIMES_A:  avs_readdata_out <= times_a_sw;
               `TCG_REG_TIMES_B:  avs_readdata_out <= times_b_sw;
               `TCG_REG_LOWTEMP:  avs_readdata_out <= {16'h0000, low_temp_threshold};
               `TCG_REG_TEMP:     avs_readdata_out <= {16'h0000, temp_s2};
               `TCG_REG_STATUS:   avs_readdata_out <= {24'h000000, 1'b0, refused,
                  low_alarm_enable_out, fault, state, lamp_out, compressor_out};
               `TCG_REG_PULLDOWN: avs_readdata_out <= {31'h00000000, pulldown_req};
               default:           avs_readdata_out <= 32'h00000000;
            endcase
         end
      end
   end

   // Register writes; setpoint outside limits is refused
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         setpoint           <= `TCG_RST_SETPOINT;
         hyst               <= `TCG_RST_HYST;
         floor_lim          <= `TCG_RST_FLOOR;
         ceil_lim           <= `TCG_RST_CEIL;
         heat_cool_select   <= 1'b0;
         low_temp_threshold <= `TCG_RST_LOWTEMP;
         refused            <= 1'b0;
      end else if (bus_wr && avs_byteenable_in[0]) begin
         case (avs_address_in)
            `TCG_REG_SETPOINT: begin
               if (sgt(floor_lim, wdata16) || sgt(wdata16, ceil_lim)) begin
                  refused <= 1'b1;
               end else begin
                  setpoint <= wdata16;
                  refused  <= 1'b0;
               end
            end
            `TCG_REG_HYST:     hyst               <= wdata16;
            `TCG_REG_FLOOR:    floor_lim          <= wdata16;
            `TCG_REG_CEIL:     ceil_lim           <= wdata16;
            `TCG_REG_MODE:     heat_cool_select   <= avs_writedata_in[0];
            `TCG_REG_LOWTEMP:  low_temp_threshold <= wdata16;
            default:           refused            <= refused;
         endcase
      end
   end

   // Time settings kept over reset, so a power cycle can bring them in
   always @(posedge clk_in) begin
      if (bus_wr && avs_byteenable_in[0] && avs_address_in == `TCG_REG_TIMES_A)
         times_a_sw <= avs_writedata_in;
      if (bus_wr && avs_byteenable_in[0] && avs_address_in == `TCG_REG_TIMES_B)
         times_b_sw <= avs_writedata_in;
   end

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Temperature word assumed to change slowly versus the tick
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         fault_s1 <= 1'b0;
         fault_s2 <= 1'b0;
         temp_s1  <= 16'h0000;
         temp_s2  <= 16'h0000;
      end else begin
         fault_s1 <= sensor_fault_in;
         fault_s2 <= fault_s1;
         temp_s1  <= temp_in;
         temp_s2  <= temp_s1;
      end
   end
   assign fault = fault_s2;

   // ****************************************
   // Base tick and power-on capture of times
   // ****************************************
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tick_div   <= 25'h0000000;
         tick       <= 1'b0;
         first_tick <= 1'b1;
         times_a    <= `TCG_RST_TIMES_A;
         times_b    <= `TCG_RST_TIMES_B;
      end else begin
         tick <= 1'b0;
         if (tick_div == TICK_CYCLES - 1) begin
            tick_div <= 25'h0000000;
            tick     <= 1'b1;
         end else begin
            tick_div <= tick_div + 25'h0000001;
         end
         // Times latch once after reset; later writes wait for a reset
         if (first_tick) begin
            times_a    <= times_a_sw;
            times_b    <= times_b_sw;
            first_tick <= 1'b0;
         end
      end
   end

   // ****************************************
   // Minute timers
   // ****************************************
   tcg_min_timer #(.WIDTH(TW)) u_power (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .tick_in     (tick),
      .restart_in  (1'b0),
      .minutes_out (since_power)
   );

   tcg_min_timer #(.WIDTH(TW)) u_start (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .tick_in     (tick),
      .restart_in  (tick && !compressor_out && next_on),
      .minutes_out (since_start)
   );

   tcg_min_timer #(.WIDTH(TW)) u_change (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .tick_in     (tick),
      .restart_in  (tick && (compressor_out != next_on)),
      .minutes_out (since_change)
   );

   tcg_min_timer #(.WIDTH(TW)) u_phase (
      .clk_in      (clk_in),
      .reset_n_in  (reset_n_in),
      .tick_in     (tick),
      .restart_in  (tick && (phase_restart || state != ST_FAULT)),
      .minutes_out (phase_min)
   );

   // ****************************************
   // Control decision
   // ****************************************
   always @* begin
      next_state     = state;
      next_fault_off = fault_off;
      phase_restart  = 1'b0;
      want_on        = compressor_out;
      // Start needs delay, start-to-start and off-time limits
      can_start = met(since_power, times_a[`TCG_FA_DELAY])
         && (!started_once || met(since_start, times_a[`TCG_FA_S2S]))
         && met(since_change, times_a[`TCG_FA_OFF]);
      can_stop  = met(since_change, times_a[`TCG_FA_ON]);
      if (!heat_cool_select) begin
         if (sgt(temp_s2, setpoint + hyst))
            want_on = 1'b1;
         else if (!sgt(temp_s2, setpoint))
            want_on = 1'b0;
      end else begin
         if (sgt(setpoint - hyst, temp_s2))
            want_on = 1'b1;
         else if (!sgt(setpoint, temp_s2))
            want_on = 1'b0;
      end
      case (state)
         ST_NORMAL: begin
            if (fault) begin
               next_state     = ST_FAULT;
               phase_restart  = 1'b1;
               next_fault_off = compressor_out;
            end else if (pulldown_req && times_b[`TCG_FB_PULL] != 8'h00) begin
               next_state = ST_PULLDOWN;
            end
         end
         ST_PULLDOWN: begin
            want_on = 1'b1;
            if (fault) begin
               next_state     = ST_FAULT;
               phase_restart  = 1'b1;
               next_fault_off = compressor_out;
            end else if (hours_run >= {8'h00, times_b[`TCG_FB_PULL]} * `TCG_MINS_PER_HOUR
                         || !sgt(temp_s2, low_temp_threshold)) begin
               next_state = ST_NORMAL;
            end
         end
         ST_FAULT: begin
            if (!fault) begin
               next_state = ST_NORMAL;
            end else if (times_b[`TCG_FB_FRUN] == 8'h00) begin
               want_on = 1'b0;
            end else if (times_b[`TCG_FB_FRUN] == `TCG_FAULT_RUN_ALWAYS) begin
               want_on = 1'b1;
            end else if (fault_off) begin
               want_on = 1'b0;
               if (phase_min >= `TCG_FAULT_OFF_MIN) begin
                  next_fault_off = 1'b0;
                  phase_restart  = 1'b1;
               end
            end else begin
               want_on = 1'b1;
               if (compressor_out && phase_min >= times_b[`TCG_FB_FRUN]) begin
                  next_fault_off = 1'b1;
                  phase_restart  = 1'b1;
               end else if (!compressor_out) begin
                  phase_restart = 1'b1;
               end
            end
         end
         default: next_state = ST_NORMAL;
      endcase
      // Fault entry stops regardless of on time; a start waits for the fault state
      if (state != ST_FAULT && fault)
         next_on = 1'b0;
      else if (state == ST_FAULT && fault && !want_on)
         next_on = 1'b0;
      else if (want_on && !compressor_out)
         next_on = can_start;
      else if (!want_on && compressor_out)
         next_on = !can_stop;
      else
         next_on = compressor_out;
      if (!met(since_power, times_a[`TCG_FA_DELAY]))
         next_on = 1'b0;
   end

   // ****************************************
   // State update on each tick
   // ****************************************
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state          <= ST_NORMAL;
         compressor_out <= 1'b0;
         fault_off      <= 1'b0;
         started_once   <= 1'b0;
         pulldown_req   <= 1'b0;
      end else begin
         if (bus_wr && avs_address_in == `TCG_REG_PULLDOWN && avs_byteenable_in[0])
            pulldown_req <= avs_writedata_in[0] && !fault;
         else if (tick && (state == ST_PULLDOWN || fault))
            pulldown_req <= 1'b0;
         if (tick) begin
            state          <= next_state;
            compressor_out <= next_on;
            fault_off      <= next_fault_off;
            if (next_on && !compressor_out)
               started_once <= 1'b1;
         end
      end
   end

   // ****************************************
   // Pull-down run and alarm hold-off timers
   // ****************************************
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hours_run            <= 16'h0000;
         hold_min             <= 16'h0000;
         low_alarm_enable_out <= 1'b1;
      end else if (tick) begin
         if (state == ST_PULLDOWN) begin
            hours_run <= (u_phase_min_edge) ? hours_run + 16'h0001 : hours_run;
         end else begin
            hours_run <= 16'h0000;
         end
         if (state == ST_PULLDOWN && next_state != ST_PULLDOWN) begin
            hold_min             <= {8'h00, times_b[`TCG_FB_HOLD]} * `TCG_MINS_PER_HOUR;
            low_alarm_enable_out <= (times_b[`TCG_FB_HOLD] == 8'h00);
         end else if (hold_min != 16'h0000) begin
            if (u_phase_min_edge)
               hold_min <= hold_min - 16'h0001;
         end else begin
            low_alarm_enable_out <= 1'b1;
         end
      end
   end

   // Minute edge from a free tick counter
   assign u_phase_min_edge = (min_ticks == `TCG_TICKS_PER_MIN - 9'h001);
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         min_ticks <= 9'h000;
      else if (tick)
         min_ticks <= u_phase_min_edge ? 9'h000 : min_ticks + 9'h001;
   end

   // ****************************************
   // Indicator lamp
   // ****************************************
   // Flashes in fault off phases, else follows the new compressor level,
   // taken on the same tick so the lamp never lags a start
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         blink    <= 8'h00;
         lamp_out <= 1'b0;
      end else if (tick) begin
         blink <= (blink == `TCG_BLINK_TICKS) ? 8'h00 : blink + 8'h01;
         if (next_state == ST_FAULT && !next_on && times_b[`TCG_FB_FRUN] != 8'h00) begin
            if (blink == `TCG_BLINK_TICKS)
               lamp_out <= !lamp_out;
         end else begin
            lamp_out <= next_on;
         end
      end
   end

endmodule

// File: rtl/tcg_consts.vh
`ifndef TCG_CONSTS_VH
`define TCG_CONSTS_VH

// Base tick timing
`define TCG_CLK_HZ          100000000
`define TCG_TICK_MS         200
`define TCG_TICK_CYCLES     (`TCG_CLK_HZ / 1000 * `TCG_TICK_MS)
`define TCG_TICKS_PER_MIN   9'h12C
`define TCG_MINS_PER_HOUR   16'h003C

// Fixed fault off time, minutes
`define TCG_FAULT_OFF_MIN   8'h0F
// Fault-run value meaning always on
`define TCG_FAULT_RUN_ALWAYS 8'h64

// Register offsets (word addresses)
`define TCG_REG_SETPOINT    4'h0
`define TCG_REG_HYST        4'h1
`define TCG_REG_FLOOR       4'h2
`define TCG_REG_CEIL        4'h3
`define TCG_REG_MODE        4'h4
`define TCG_REG_TIMES_A     4'h5
`define TCG_REG_TIMES_B     4'h6
`define TCG_REG_LOWTEMP     4'h7
`define TCG_REG_TEMP        4'h8
`define TCG_REG_STATUS      4'h9
`define TCG_REG_PULLDOWN    4'hA

// Reset values
`define TCG_RST_SETPOINT    16'h0000
`define TCG_RST_HYST        16'h0002
`define TCG_RST_FLOOR       16'hFFD8
`define TCG_RST_CEIL        16'h005A
`define TCG_RST_LOWTEMP     16'hFFD8
`define TCG_RST_TIMES_A     32'h00000000
`define TCG_RST_TIMES_B     32'h00020400

// Field positions in TIMES_A: delay, s2s, off, on (bytes)
`define TCG_FA_DELAY        7:0
`define TCG_FA_S2S          15:8
`define TCG_FA_OFF          23:16
`define TCG_FA_ON           31:24
// Field positions in TIMES_B: fault run, pulldown hours, hold hours
`define TCG_FB_FRUN         7:0
`define TCG_FB_PULL         15:8
`define TCG_FB_HOLD         23:16

// Lamp blink count end, ticks; half period is this plus one
`define TCG_BLINK_TICKS     8'h05

`endif

// File: rtl/tcg_min_timer.v
`timescale 1ns/10ps
`include "tcg_consts.vh"

// Counts elapsed minutes since restart, saturating
module tcg_min_timer #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input  wire             clk_in,
   input  wire             reset_n_in,
   // Control
   input  wire             tick_in,
   input  wire             restart_in,
   // Elapsed minutes
   output wire [WIDTH-1:0] minutes_out
);

   reg [8:0]       tick_count;
   reg [WIDTH-1:0] minutes;

   assign minutes_out = minutes;

   // ****************************************
   // Minute counting from base ticks
   // ****************************************
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tick_count <= 9'h000;
         minutes    <= {WIDTH{1'b0}};
      end else if (restart_in) begin
         tick_count <= 9'h000;
         minutes    <= {WIDTH{1'b0}};
      end else if (tick_in) begin
         if (tick_count == `TCG_TICKS_PER_MIN - 9'h001) begin
            tick_count <= 9'h000;
            if (minutes != {WIDTH{1'b1}})
               minutes <= minutes + 1'b1;
         end else begin
            tick_count <= tick_count + 9'h001;
         end
      end
   end

endmodule

// File: sim/tcg_meas_model.sv
`timescale 1ns/10ps
// ****************
// Measurement path model
// ****************
module tcg_meas_model (
   // Clock
   input  wire        clk_in,
   // Wanted sensor values
   input  wire [15:0] temp_req_in,
   input  wire        fault_req_in,
   // Toward the block
   output reg  [15:0] temp_out,
   output reg         fault_out
);
   // Sensor path lags one clock, so the block never sees a same-edge change
   always @(posedge clk_in) begin
      temp_out  <= temp_req_in;
      fault_out <= fault_req_in;
   end
endmodule

// File: sim/tcg_guard_properties.sv
`timescale 1ns/10ps
// ****************
// Port checker
// ****************
module tcg_guard_checker (
   input wire        clk_in,
   input wire        reset_n_in,
   input wire        avs_read_in,
   input wire        avs_write_in,
   input wire [31:0] avs_readdata_out,
   input wire        avs_waitrequest_out,
   input wire        compressor_out,
   input wire        lamp_out,
   input wire        low_alarm_enable_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // Read answer: one wait cycle, then data
   sequence s_read_ans;
      avs_waitrequest_out ##1 !avs_waitrequest_out;
   endsequence
   a_read_one_wait: assert property ($rose(avs_read_in) |-> s_read_ans)
      else $error("read wait count wrong");
   a_write_no_wait: assert property (avs_write_in |-> !avs_waitrequest_out)
      else $error("write stalled");
   a_wait_only_read: assert property (avs_waitrequest_out |-> avs_read_in)
      else $error("wait without read");
   a_data_stands: assert property (!avs_read_in && !$past(avs_read_in) && !$past(avs_read_in, 2)
      |-> $stable(avs_readdata_out)) else $error("read data moved");
   // Outputs move only on base ticks, two clocks apart here
   a_comp_tick_gap: assert property ($changed(compressor_out) |=> $stable(compressor_out))
      else $error("compressor changed off tick");
   a_lamp_tick_gap: assert property ($changed(lamp_out) |=> $stable(lamp_out))
      else $error("lamp changed off tick");
   a_alarm_tick_gap: assert property ($changed(low_alarm_enable_out) |=>
      $stable(low_alarm_enable_out)) else $error("alarm enable changed off tick");
   a_lamp_when_run: assert property (compressor_out |-> lamp_out)
      else $error("lamp dark while running");
endmodule

// File: sim/thermostat_compressor_guard_bench.sv
`timescale 1ns/10ps
`define CHK(nm, e, s) begin checks = checks + 1; if ((s) !== (e)) begin \
   error_cnt = error_cnt + 1; $display("ERROR %s exp %0h got %0h", nm, e, s); end end
// ****************
// Bench top
// ****************
module thermostat_compressor_guard_bench;
   localparam MIN = 600;
   reg         clk_in;
   reg         reset_n_in;
   reg  [3:0]  adr;
   reg         rd;
   reg         wr;
   reg  [31:0] wd;
   reg  [15:0] t_req;
   reg         f_req;
   reg  [31:0] d;
   wire [31:0] rdata;
   wire        wreq;
   wire [15:0] temp;
   wire        fault;
   wire        comp;
   wire        lamp;
   wire        alarm;
   integer     error_cnt;
   integer     checks;
   integer     cyc;
   integer     n;
   // Two-clock tick keeps a minute at 600 clocks
   tcg_guard #(.TICK_CYCLES(2)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
      .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
      .temp_in(temp), .sensor_fault_in(fault), .compressor_out(comp), .lamp_out(lamp),
      .low_alarm_enable_out(alarm));
   tcg_meas_model meas (.clk_in(clk_in), .temp_req_in(t_req), .fault_req_in(f_req),
      .temp_out(temp), .fault_out(fault));
   // Bus cycles hold until waitrequest is seen low
   task bus_wr(input [3:0] a, input [31:0] v);
      begin
         @(posedge clk_in);
         adr <= a;
         wd <= v;
         wr <= 1'b1;
         do @(posedge clk_in); while (wreq !== 1'b0);
         wr <= 1'b0;
      end
   endtask
   task bus_rd(input [3:0] a);
      begin
         @(posedge clk_in);
         adr <= a;
         rd <= 1'b1;
         do @(posedge clk_in); while (wreq !== 1'b0);
         d = rdata;
         rd <= 1'b0;
      end
   endtask
   task set_t(input [15:0] v, input f);
      begin
         @(posedge clk_in);
         t_req <= v;
         f_req <= f;
      end
   endtask
   // Bounded wait for the compressor level, n counts clocks
   task wait_comp(input v, input integer lim);
      begin
         n = 0;
         while (comp !== v && n < lim) begin
            @(negedge clk_in);
            n = n + 1;
         end
      end
   endtask
   task finish_test;
      begin
         $display("errors %0d checks %0d", error_cnt, checks);
         if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // Reset values, unmapped place, setpoint limits
   task t_regs;
      begin
         bus_rd(4'h1); `CHK("hyst", 16'h0002, d[15:0])
         bus_rd(4'h4); `CHK("mode", 1'b0, d[0])
         bus_rd(4'h6); `CHK("times_b", 32'h00020400, d)
         bus_rd(4'hF); `CHK("unmapped", 32'h00000000, d)
         bus_wr(4'h0, 32'h0000FFD7); bus_rd(4'h0); `CHK("sp low", 16'h0000, d[15:0])
         bus_rd(4'h9); `CHK("refused", 1'b1, d[6])
         bus_wr(4'h0, 32'h0000005B); bus_rd(4'h0); `CHK("sp high", 16'h0000, d[15:0])
         bus_wr(4'h0, 32'h0000005A); bus_rd(4'h0); `CHK("sp ceil", 16'h005A, d[15:0])
         bus_wr(4'h0, 32'h0000FFD8); bus_rd(4'h0); `CHK("sp floor", 16'hFFD8, d[15:0])
         bus_wr(4'h0, 32'h00000000);
      end
   endtask
   // Band edges in cooling, then heating
   task t_band;
      begin
         set_t(16'h0002, 1'b0); repeat (30) @(negedge clk_in); `CHK("cool edge", 1'b0, comp)
         set_t(16'h0003, 1'b0); wait_comp(1'b1, 40); `CHK("cool on", 1'b1, comp)
         set_t(16'h0001, 1'b0); repeat (30) @(negedge clk_in); `CHK("cool band", 1'b1, comp)
         set_t(16'h0000, 1'b0); wait_comp(1'b0, 40); `CHK("cool off", 1'b0, comp)
         bus_wr(4'h4, 32'h00000001);
         set_t(16'hFFFE, 1'b0); repeat (30) @(negedge clk_in); `CHK("heat edge", 1'b0, comp)
         set_t(16'hFFFD, 1'b0); wait_comp(1'b1, 40); `CHK("heat on", 1'b1, comp)
         set_t(16'h0000, 1'b0); wait_comp(1'b0, 40); `CHK("heat off", 1'b0, comp)
         bus_wr(4'h4, 32'h00000000);
      end
   endtask
   // Pull-down ends at the low threshold and holds the alarm off
   task t_pull;
      begin
         bus_wr(4'hA, 32'h00000001); wait_comp(1'b1, 40); `CHK("pull on", 1'b1, comp)
         bus_rd(4'h9); `CHK("pull state", 2'h1, d[3:2])
         set_t(16'hFFD8, 1'b0); wait_comp(1'b0, 40); `CHK("pull end", 1'b0, comp)
         repeat (10) @(negedge clk_in); `CHK("alarm hold", 1'b0, alarm)
         set_t(16'h0003, 1'b0); wait_comp(1'b1, 40);
         set_t(16'h0003, 1'b1); wait_comp(1'b0, 40); `CHK("fault stop", 1'b0, comp)
         bus_wr(4'hA, 32'h00000001); bus_rd(4'h9); `CHK("no pull", 2'h2, d[3:2])
         repeat (2000) @(negedge clk_in); `CHK("fault run 0", 1'b0, comp)
         set_t(16'h0000, 1'b0);
      end
   endtask
   // Saved times apply after a power cycle; fault duty cycling
   task t_times;
      begin
         bus_wr(4'h5, 32'h01000001);
         bus_wr(4'h6, 32'h00020401);
         set_t(16'h0003, 1'b0);
         reset_n_in <= 1'b0;
         repeat (6) @(posedge clk_in);
         reset_n_in <= 1'b1;
         wait_comp(1'b1, 2 * MIN);
         `CHK("start delay", 1'b1, n >= MIN - 20 && n < MIN + 40)
         set_t(16'h0000, 1'b0);
         wait_comp(1'b0, 2 * MIN);
         `CHK("min on", 1'b1, n >= MIN - 20 && n < MIN + 40)
         set_t(16'h0000, 1'b1); wait_comp(1'b1, 60); `CHK("fault start", 1'b1, comp)
         wait_comp(1'b0, 2 * MIN);
         `CHK("fault on", 1'b1, n >= MIN - 20 && n < MIN + 40)
         n = 0;
         repeat (200) @(negedge clk_in) n = n + (lamp === 1'b1);
         `CHK("flash", 1'b1, n > 0 && n < 200)
         wait_comp(1'b1, 16 * MIN);
         `CHK("fault off", 1'b1, n >= 15 * MIN - 240 && n < 15 * MIN)
      end
   endtask
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Hang guard
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt = error_cnt + 1;
         finish_test;
      end
   end
   initial begin
      reset_n_in = 1'b0;
      {adr, rd, wr, wd, t_req, f_req} = 0;
      error_cnt = 0;
      checks = 0;
      cyc = 0;
      repeat (6) @(posedge clk_in);
      reset_n_in <= 1'b1;
      t_regs;
      t_band;
      t_pull;
      t_times;
      finish_test;
   end
endmodule
bind tcg_guard tcg_guard_checker chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .compressor_out(compressor_out), .lamp_out(lamp_out),
   .low_alarm_enable_out(low_alarm_enable_out));
